/* File: pwm_output_steer.sv */
// Strobed register access was chosen for this implementation.
`default_nettype none
module pwm_output_steer
  import pwm_steer_pkg::*;
(
  input  wire logic                      clk_sys_in,
  input  wire logic                      resetn_in,
  input  wire logic [pwm_steer_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [pwm_steer_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                      wr_en_in,
  input  wire logic                      rd_en_in,
  output logic      [pwm_steer_pkg::DATA_W-1:0] rd_data_out,
  input  wire logic                      pwm_raw_in,
  input  wire logic                      period_start_in,
  input  wire logic                      comp1_in,
  input  wire logic                      comp2_in,
  input  wire logic                      int_pin_in,
  output logic                           pwm_out_a_out,
  output logic                           pwm_out_b_out,
  output logic                           pwm_out_c_out,
  output logic                           pwm_out_d_out,
  output logic                           pwm_oe_n_a_out,
  output logic                           pwm_oe_n_b_out,
  output logic                           pwm_oe_n_c_out,
  output logic                           pwm_oe_n_d_out,
  output logic                           port_own_a_out,
  output logic                           port_own_b_out,
  output logic                           port_own_c_out,
  output logic                           port_own_d_out
);
  import pwm_steer_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                  int_meta;
    logic                  int_sync;
    steer_t                steer;
    logic [3:0]            steer_act;
    restart_db_t           rdb;
    shutdown_ctrl_t        sdc;
    mode_t                 mode;
    shut_state_t           sd;
    logic [1:0]            sched_prev;
    logic [1:0][DELAY_W-1:0] db_cnt;
    logic [DATA_W-1:0]     rd_data;
  } state_t;

  state_t                  st_reg;
  state_t                  st_next;
  logic                    steer_mode;
  logic                    half_mode;
  logic                    pwm_mode;
  logic                    cause;
  logic                    force_sd;
  logic                    steer_wr;
  logic                    sdc_wr;
  logic                    rise_a;
  steer_t                  wr_steer;
  logic [1:0]              db_act;
  logic [3:0]              pin_en;
  logic [3:0]              pin_val;
  logic [3:0]              pin_oe_n;
  logic [3:0]              port_own;
  logic                    sched;
  logic                    rise;
  logic [DELAY_W-1:0]      cnt_eff;
  logic                    pol_low;
  logic                    level;
  pss_t                    pss;

  // ****************************************
  // Decode
  // ****************************************
  assign pwm_mode   = (st_reg.mode.mode_hi == MODE_PWM);
  assign steer_mode = pwm_mode && (st_reg.mode.cfg == CFG_SINGLE);
  assign half_mode  = pwm_mode && (st_reg.mode.cfg == CFG_HALF);
  assign steer_wr   = wr_en_in && (addr_in == ADDR_STEER);
  assign sdc_wr     = wr_en_in && (addr_in == ADDR_SHUTDOWN);
  assign wr_steer   = steer_t'(wr_data_in[STEER_W-1:0]);
  assign rise_a     = pwm_raw_in && !st_reg.sched_prev[0];

  // Shutdown cause, comparators act without a clock edge
  assign cause = (st_reg.sdc.src.comp1 && comp1_in)
              || (st_reg.sdc.src.comp2 && comp2_in)
              || (st_reg.sdc.src.int_pin && !st_reg.int_sync);
  assign force_sd = cause || (st_reg.sd != SD_RUN);

  // ****************************************
  // Next state and pins
  // ****************************************
  always_comb begin
    st_next  = st_reg;
    sched    = 1'b0;
    rise     = 1'b0;
    cnt_eff  = '0;
    pol_low  = 1'b0;
    level    = 1'b0;
    pss      = '0;
    db_act   = '0;
    pin_en   = '0;
    pin_val  = '0;
    pin_oe_n = '1;
    port_own = '1;
    st_next.int_meta = int_pin_in;
    st_next.int_sync = st_reg.int_meta;

    // Period boundary copy of shadow enables
    if (period_start_in && st_reg.steer.sync) begin
      st_next.steer_act = st_reg.steer.en;
    end

    if (wr_en_in) begin
      case (addr_in)
        ADDR_RESTART_DB: st_next.rdb = restart_db_t'(wr_data_in);
        ADDR_SHUTDOWN:   st_next.sdc = shutdown_ctrl_t'(wr_data_in[SDC_W-1:0]);
        ADDR_MODE:       st_next.mode = mode_t'(wr_data_in);
        ADDR_STEER: begin
          st_next.steer = wr_steer;
          if (!wr_steer.sync) begin
            st_next.steer_act = wr_steer.en;
          end
        end
        default: ;
      endcase
    end

    // Shutdown sequencing, set beats clear
    case (st_reg.sd)
      SD_RUN: begin
        if (cause || (sdc_wr && wr_data_in[FLAG_BIT])) begin
          st_next.sd = SD_HOLD;
        end
      end
      SD_HOLD: begin
        if (!cause && st_reg.rdb.restart) begin
          st_next.sd = SD_RESUME;
        end else if (!cause && sdc_wr && !wr_data_in[FLAG_BIT]) begin
          st_next.sd = SD_RESUME;
        end
      end
      SD_RESUME: begin
        if (cause || (sdc_wr && wr_data_in[FLAG_BIT])) begin
          st_next.sd = SD_HOLD;
        end else if (period_start_in) begin
          st_next.sd = SD_RUN;
        end
      end
      default: st_next.sd = SD_HOLD;
    endcase

    st_next.rd_data = '0;
    if (rd_en_in) begin
      case (addr_in)
        ADDR_RESTART_DB: st_next.rd_data = st_reg.rdb;
        ADDR_SHUTDOWN:
          st_next.rd_data = {st_reg.sd == SD_HOLD, st_reg.sdc};
        ADDR_STEER:
          st_next.rd_data = {3'h0, st_reg.steer};
        ADDR_MODE:       st_next.rd_data = st_reg.mode;
        default:         st_next.rd_data = '0;
      endcase
    end

    // Dead band on both half-bridge channels
    for (int c = 0; c < 2; c++) begin
      sched   = (c == PIN_A) ? pwm_raw_in : !pwm_raw_in;
      rise    = sched && !st_reg.sched_prev[c];
      cnt_eff = rise ? st_reg.rdb.delay : st_reg.db_cnt[c];
      db_act[c] = sched && (cnt_eff == '0);
      st_next.db_cnt[c] = (sched && (cnt_eff != '0))
                        ? cnt_eff - 7'h01 : '0;
      st_next.sched_prev[c] = sched;
    end

    // Pin steering and shutdown override
    for (int i = 0; i < 4; i++) begin
      if ((i == PIN_A) || (i == PIN_C)) begin
        pol_low = st_reg.mode.pol_ac_low;
        pss     = st_reg.sdc.pss_ac;
      end else begin
        pol_low = st_reg.mode.pol_bd_low;
        pss     = st_reg.sdc.pss_bd;
      end
      if (steer_mode) begin
        pin_en[i] = st_reg.steer_act[i];
      end else if (half_mode) begin
        pin_en[i] = (i == PIN_A) || (i == PIN_B);
      end else begin
        pin_en[i] = pwm_mode && (i == PIN_A);
      end
      level = half_mode ? db_act[i == PIN_B] : pwm_raw_in;
      if (!pin_en[i]) begin
        pin_val[i]  = 1'b0;
        pin_oe_n[i] = 1'b1;
        port_own[i] = 1'b1;
      end else if (force_sd) begin
        port_own[i] = 1'b0;
        pin_oe_n[i] = pss.tri_st;
        pin_val[i]  = !pss.tri_st && pss.level;
      end else begin
        port_own[i] = 1'b0;
        pin_oe_n[i] = 1'b0;
        pin_val[i]  = level ^ pol_low;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg           <= '0;
      st_reg.int_meta  <= 1'b1;
      st_reg.int_sync  <= 1'b1;
      st_reg.steer     <= STEER_RESET;
      st_reg.steer_act <= STEER_ACT_RESET;
      st_reg.rdb       <= RESTART_DB_RESET;
      st_reg.sdc       <= SHUTDOWN_RESET;
      st_reg.mode      <= MODE_RESET;
      st_reg.sd        <= SD_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_data_out    = st_reg.rd_data;
  assign pwm_out_a_out  = pin_val[PIN_A];
  assign pwm_out_b_out  = pin_val[PIN_B];
  assign pwm_out_c_out  = pin_val[PIN_C];
  assign pwm_out_d_out  = pin_val[PIN_D];
  assign pwm_oe_n_a_out = pin_oe_n[PIN_A];
  assign pwm_oe_n_b_out = pin_oe_n[PIN_B];
  assign pwm_oe_n_c_out = pin_oe_n[PIN_C];
  assign pwm_oe_n_d_out = pin_oe_n[PIN_D];
  assign port_own_a_out = port_own[PIN_A];
  assign port_own_b_out = port_own[PIN_B];
  assign port_own_c_out = port_own[PIN_C];
  assign port_own_d_out = port_own[PIN_D];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  property p_gate;
    (!steer_mode && !half_mode)
      |-> (port_own[PIN_B] && port_own[PIN_C] && port_own[PIN_D]);
  endproperty
  a_gate: assert property (p_gate)
    else $error("extra pin driven outside steering");

  property p_steer_a;
    (steer_mode && st_reg.steer_act[PIN_A] && !force_sd)
      |-> (!pin_oe_n[PIN_A]
           && (pin_val[PIN_A] == (pwm_raw_in ^ st_reg.mode.pol_ac_low)));
  endproperty
  a_steer_a: assert property (p_steer_a)
    else $error("steered pin A wrong level");

  property p_immed;
    (steer_wr && !wr_steer.sync)
      |=> (st_reg.steer_act == $past(wr_steer.en));
  endproperty
  a_immed: assert property (p_immed)
    else $error("immediate steering not applied");

  property p_sync;
    (st_reg.steer.sync && !steer_wr && !period_start_in)
      |=> $stable(st_reg.steer_act);
  endproperty
  a_sync: assert property (p_sync)
    else $error("steering changed mid period");

  property p_rsvd;
    (rd_en_in && (addr_in == ADDR_STEER))
      |=> (rd_data_out[DATA_W-1:STEER_W] == '0);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved steering bits not zero");

  property p_fall;
    (half_mode && !force_sd && $changed(pwm_raw_in))
      |-> (pwm_raw_in ? (pin_val[PIN_B] == st_reg.mode.pol_bd_low)
                      : (pin_val[PIN_A] == st_reg.mode.pol_ac_low));
  endproperty
  a_fall: assert property (p_fall)
    else $error("inactive edge was delayed");
  property p_delay;
    (rise_a && (st_reg.rdb.delay == 7'h02)) ##1 pwm_raw_in [*2]
      |-> (db_act[0] && $past(!db_act[0]));
  endproperty
  a_delay: assert property (p_delay)
    else $error("dead band count wrong");
  property p_restart;
    (st_reg.sd == SD_HOLD && st_reg.rdb.restart && !cause)
      |=> (st_reg.sd == SD_RESUME);
  endproperty
  a_restart: assert property (p_restart)
    else $error("auto restart missed");
  property p_manual;
    (st_reg.sd == SD_HOLD && !st_reg.rdb.restart && !sdc_wr)
      |=> (st_reg.sd == SD_HOLD);
  endproperty
  a_manual: assert property (p_manual)
    else $error("shutdown left without software");
  property p_async;
    (cause && steer_mode && st_reg.steer_act[PIN_A]
     && (st_reg.sdc.pss_ac == pss_t'(PSS_LOW)))
      |-> (!pin_val[PIN_A] && !pin_oe_n[PIN_A]);
  endproperty
  a_async: assert property (p_async)
    else $error("pin A not forced low at once");
  property p_nosrc;
    (st_reg.sdc.src == '0 && st_reg.sd == SD_RUN && !sdc_wr)
      |=> (st_reg.sd == SD_RUN);
  endproperty
  a_nosrc: assert property (p_nosrc)
    else $error("shutdown without source");
  property p_level;
    (st_reg.sd == SD_HOLD && cause) |=> (st_reg.sd == SD_HOLD);
  endproperty
  a_level: assert property (p_level)
    else $error("flag cleared while cause active");
  property p_flag;
    (rd_en_in && (addr_in == ADDR_SHUTDOWN) && st_reg.sd == SD_HOLD)
      |=> rd_data_out[FLAG_BIT];
  endproperty
  a_flag: assert property (p_flag)
    else $error("shutdown flag reads clear");
  property p_tri;
    (force_sd && steer_mode && st_reg.steer_act[PIN_B]
     && st_reg.sdc.pss_bd.tri_st) |-> pin_oe_n[PIN_B];
  endproperty
  a_tri: assert property (p_tri)
    else $error("pin B not floated");

  property p_shadow;
    (period_start_in && st_reg.steer.sync && !steer_wr)
      |=> (st_reg.steer_act == $past(st_reg.steer.en));
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow not copied at boundary");
endmodule
`default_nettype wire

/* File: pwm_steer_pkg.sv */
`default_nettype none
package pwm_steer_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int         ADDR_W          = 9;
  localparam int         DATA_W          = 8;
  localparam int         DELAY_W         = 7;
  localparam logic [8:0] ADDR_MODE       = 9'h017;
  localparam logic [8:0] ADDR_RESTART_DB = 9'h01C;
  localparam logic [8:0] ADDR_SHUTDOWN   = 9'h01D;
  localparam logic [8:0] ADDR_STEER      = 9'h19D;
  localparam int         FLAG_BIT        = 7;

  // ****************************************
  // Field layouts
  // ****************************************
  typedef struct packed {
    logic             restart;
    logic [6:0]       delay;
  } restart_db_t;

  typedef struct packed {
    logic             int_pin;
    logic             comp2;
    logic             comp1;
  } src_sel_t;

  typedef struct packed {
    logic             tri_st;
    logic             level;
  } pss_t;

  typedef struct packed {
    src_sel_t         src;
    pss_t             pss_ac;
    pss_t             pss_bd;
  } shutdown_ctrl_t;

  typedef struct packed {
    logic             sync;
    logic [3:0]       en;
  } steer_t;

  typedef struct packed {
    logic [1:0]       cfg;
    logic [1:0]       spare;
    logic [1:0]       mode_hi;
    logic             pol_ac_low;
    logic             pol_bd_low;
  } mode_t;

  localparam int          SDC_W            = $bits(shutdown_ctrl_t);
  localparam int          STEER_W          = $bits(steer_t);

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [4:0]  STEER_RESET      = 5'h01;
  localparam logic [3:0]  STEER_ACT_RESET  = 4'h1;
  localparam logic [7:0]  RESTART_DB_RESET = 8'h00;
  localparam logic [6:0]  SHUTDOWN_RESET   = 7'h00;
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  localparam logic [1:0]  MODE_PWM         = 2'h3;
  localparam logic [1:0]  CFG_SINGLE       = 2'h0;
  localparam logic [1:0]  CFG_HALF         = 2'h2;
  localparam logic [1:0]  PSS_LOW          = 2'h0;
  localparam int          PIN_A            = 0;
  localparam int          PIN_B            = 1;
  localparam int          PIN_C            = 2;
  localparam int          PIN_D            = 3;

  typedef enum logic [2:0] {
    SD_RUN    = 3'b001,
    SD_HOLD   = 3'b010,
    SD_RESUME = 3'b100
  } shut_state_t;
endpackage
`default_nettype wire

/* File: pwm_timebase_model.sv */
`default_nettype none
module pwm_timebase_model (
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] duty_in,
  output var  logic       pwm_raw_out,
  output var  logic       period_start_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Timer period of 16 cycles
  // ****************************************
  logic [3:0] cnt_reg;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg          <= 4'h0;
      pwm_raw_out      <= 1'b0;
      period_start_out <= 1'b0;
    end else begin
      cnt_reg          <= cnt_reg + 4'h1;
      period_start_out <= (cnt_reg == 4'hF);
      pwm_raw_out      <= ({4'h0, cnt_reg + 4'h1} < duty_in);
    end
  end
endmodule
`default_nettype wire

/* File: pwm_output_steer_deadband_shutdown_tb_top.sv */
`default_nettype none
module pwm_output_steer_deadband_shutdown_tb_top;
  import pwm_steer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys_in = 1'b0;
  logic              resetn_in  = 1'b0;
  logic [ADDR_W-1:0] addr       = '0;
  logic [DATA_W-1:0] wdat       = '0;
  logic [DATA_W-1:0] rdat;
  logic              wr_en      = 1'b0;
  logic              rd_en      = 1'b0;
  logic              comp1      = 1'b0;
  logic              comp2      = 1'b0;
  logic              int_pin    = 1'b1;
  logic              raw;
  logic              pstart;
  logic [3:0]        po;
  logic [3:0]        oe;
  logic [3:0]        own;
  logic [3:0]        en_g       = 4'h1;
  logic [1:0]        pol_g      = 2'h0;
  logic [3:0]        pss_g      = 4'h0;
  int                fails      = 0;
  int                cmp_count  = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  pwm_timebase_model tb_model (
    .clk_sys_in       (clk_sys_in),
    .resetn_in        (resetn_in),
    .duty_in          (8'h08),
    .pwm_raw_out      (raw),
    .period_start_out (pstart)
  );

  pwm_output_steer dut (
    .clk_sys_in      (clk_sys_in),
    .resetn_in       (resetn_in),
    .addr_in         (addr),
    .wr_data_in      (wdat),
    .wr_en_in        (wr_en),
    .rd_en_in        (rd_en),
    .rd_data_out     (rdat),
    .pwm_raw_in      (raw),
    .period_start_in (pstart),
    .comp1_in        (comp1),
    .comp2_in        (comp2),
    .int_pin_in      (int_pin),
    .pwm_out_a_out   (po[0]),
    .pwm_out_b_out   (po[1]),
    .pwm_out_c_out   (po[2]),
    .pwm_out_d_out   (po[3]),
    .pwm_oe_n_a_out  (oe[0]),
    .pwm_oe_n_b_out  (oe[1]),
    .pwm_oe_n_c_out  (oe[2]),
    .pwm_oe_n_d_out  (oe[3]),
    .port_own_a_out  (own[0]),
    .port_own_b_out  (own[1]),
    .port_own_c_out  (own[2]),
    .port_own_d_out  (own[3])
  );

  // ****************************************
  // Expectations and compares
  // ****************************************
  function automatic logic [11:0] exp_pins(input logic f);
    logic [11:0] e;
    logic [1:0]  s;
    e = {4'hF, 4'hF, 4'h0};
    for (int i = 0; i < 4; i++) begin
      s = (i % 2 == 0) ? pss_g[3:2] : pss_g[1:0];
      if (en_g[i]) begin
        e[8+i] = 1'b0;
        e[4+i] = f & s[1];
        e[i]   = f ? (s[1] ? 1'b0 : s[0]) : raw ^ pol_g[i % 2 == 0];
      end
    end
    return e;
  endfunction

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: reg %h not %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic f);
    logic [11:0] e;
    e = exp_pins(f);
    cmp_count++;
    if ({own, oe, po} !== e) begin
      fails++;
      $display("wrong value at %0t: pins %h not %h", $time, {own, oe, po}, e);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_en <= 1'b1;
    addr  <= a;
    wdat  <= d;
    @(posedge clk_sys_in);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk_sys_in);
    rd_en <= 1'b0;
    @(negedge clk_sys_in);
    chk_reg(rdat, e);
  endtask

  task automatic wait_ps();
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_sys_in);
      if (pstart === 1'b1) break;
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [7:0] v;
    logic [2:0] src;
    logic       hit;
    int         k;
    void'($urandom(32'hA489));
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd_chk(ADDR_STEER, 8'h01);
    rd_chk(ADDR_RESTART_DB, 8'h00);
    rd_chk(ADDR_SHUTDOWN, 8'h00);
    rd_chk(9'h0AA, 8'h00);
    chk_reg({4'h0, own}, 8'h0F);
    wr(ADDR_STEER, 8'hFF);
    rd_chk(ADDR_STEER, 8'h1F);
    $display("test registers done");
    v = 8'($urandom);
    pol_g = v[1:0];
    wr(ADDR_MODE, {6'h03, pol_g});
    wait_ps();
    for (int i = 0; i < 8; i++) begin
      en_g = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
      wr(ADDR_STEER, {4'h0, en_g});
      repeat (3) begin
        @(negedge clk_sys_in);
        chk_pins(1'b0);
      end
    end
    wr(ADDR_MODE, 8'h4C);
    @(negedge clk_sys_in);
    chk_reg({4'h0, own}, 8'h0E);
    wr(ADDR_MODE, 8'h08);
    @(negedge clk_sys_in);
    chk_reg({4'h0, own}, 8'h0F);
    $display("test steering done");
    pol_g = 2'h0;
    en_g = 4'h3;
    wr(ADDR_MODE, 8'h0C);
    wr(ADDR_STEER, 8'h03);
    wait_ps();
    wr(ADDR_STEER, 8'h1C);
    @(negedge clk_sys_in);
    chk_pins(1'b0);
    wait_ps();
    chk_pins(1'b0);
    en_g = 4'hC;
    @(negedge clk_sys_in);
    chk_pins(1'b0);
    $display("test steering sync done");
    wr(ADDR_MODE, 8'h8C);
    for (int i = 0; i < 6; i++) begin
      v = (i < 3) ? 8'(i) : (i == 3) ? 8'($urandom_range(6, 3)) :
          (i == 4) ? 8'h07 : 8'h09;
      wr(ADDR_RESTART_DB, v);
      wait_ps();
      wait_ps();
      k = 0;
      while (po[0] !== 1'b1 && k < 16) begin
        @(negedge clk_sys_in);
        k++;
      end
      chk_reg(8'(k), (v > 8'h07) ? 8'h10 : v);
      if (v < 8'h08) begin
        repeat (8 - k) @(negedge clk_sys_in);
        chk_reg({7'h0, po[0]}, 8'h00);
        chk_reg({7'h0, po[1]}, {7'h0, v == 8'h00});
      end
    end
    $display("test dead band done");
    wr(ADDR_MODE, 8'h0C);
    wr(ADDR_RESTART_DB, 8'h00);
    en_g = 4'hF;
    wr(ADDR_STEER, 8'h0F);
    for (int i = 0; i < 24; i++) begin
      src = 3'(i / 3);
      hit = src[i % 3];
      pss_g = 4'($urandom);
      wr(ADDR_SHUTDOWN, {1'b0, src, pss_g});
      if (i % 3 == 0) comp1 <= 1'b1;
      else if (i % 3 == 1) comp2 <= 1'b1;
      else int_pin <= 1'b0;
      @(negedge clk_sys_in);
      if (i % 3 != 2) chk_pins(hit);
      repeat (3) @(negedge clk_sys_in);
      chk_pins(hit);
      rd_chk(ADDR_SHUTDOWN, {hit, src, pss_g});
      wr(ADDR_SHUTDOWN, {1'b0, src, pss_g});
      rd_chk(ADDR_SHUTDOWN, {hit, src, pss_g});
      @(posedge clk_sys_in);
      comp1 <= 1'b0;
      comp2 <= 1'b0;
      int_pin <= 1'b1;
      repeat (4) @(negedge clk_sys_in);
      chk_pins(hit);
      wr(ADDR_SHUTDOWN, {1'b0, src, pss_g});
      rd_chk(ADDR_SHUTDOWN, {1'b0, src, pss_g});
      wait_ps();
      @(negedge clk_sys_in);
      chk_pins(1'b0);
    end
    pss_g = 4'h0;
    wr(ADDR_RESTART_DB, 8'h80);
    wr(ADDR_SHUTDOWN, 8'h10);
    comp1 <= 1'b1;
    @(negedge clk_sys_in);
    chk_pins(1'b1);
    @(posedge clk_sys_in);
    comp1 <= 1'b0;
    repeat (3) @(negedge clk_sys_in);
    rd_chk(ADDR_SHUTDOWN, 8'h10);
    wait_ps();
    @(negedge clk_sys_in);
    chk_pins(1'b0);
    wr(ADDR_RESTART_DB, 8'h00);
    wr(ADDR_SHUTDOWN, 8'h80);
    @(negedge clk_sys_in);
    chk_pins(1'b1);
    rd_chk(ADDR_SHUTDOWN, 8'h80);
    $display("test shutdown done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    $display("wrong value at %0t: run did not finish", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
